// ---- design/pms_cfg.svh ----
/*
  Constants for the power-mode sequencer: wake-source bit positions,
  per-mode wake masks, settle-wait counts and clock divisor codes.
  Assumes one settle "state" equals one cycle of the 20 MHz block clock.
*/
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// Clock period of i_clk in ns
`define PMS_CLK_PERIOD_NS 50

// Wake source positions within the request vector
`define PMS_SRC_W 20
`define PMS_SRC_TIMER_A 0
`define PMS_SRC_TIMER_C 1
`define PMS_SRC_TIMER_F 2
`define PMS_SRC_TIMER_G 3
`define PMS_SRC_SERIAL_CHANNEL_ONE 4
`define PMS_SRC_SERIAL_CHANNEL_THREE_ONE 5
`define PMS_SRC_SERIAL_CHANNEL_THREE_TWO 6
`define PMS_SRC_IRQ0 7
`define PMS_SRC_WKP0 12

// Sources that may end each low-power mode
`define PMS_MASK_WATCH 20'hFF08D
`define PMS_MASK_SUBSLEEP 20'hFFFFF
`define PMS_MASK_STANDBY 20'hFF180
`define PMS_MASK_SLEEP 20'hFFFFF

// Settle wait counts, in states, selected by the three select bits
`define PMS_WAIT_1024 15'h0400
`define PMS_WAIT_2048 15'h0800
`define PMS_WAIT_4096 15'h1000
`define PMS_WAIT_2 15'h0002
`define PMS_WAIT_8 15'h0008
`define PMS_WAIT_16 15'h0010
`define PMS_WAIT_8192_DEF 8192
`define PMS_WAIT_16384_DEF 16384

// CPU divisor as log2: subactive /8, /4, /2; medium-speed base /8
`define PMS_SUB_LOG2_DIV8 3'h3
`define PMS_SUB_LOG2_DIV4 3'h2
`define PMS_SUB_LOG2_DIV2 3'h1
`define PMS_MID_LOG2_BASE 3'h3

// Reset value of the subactive clock select
`define PMS_SA_RESET 2'h0

`endif

// ---- design/pms_pkg.sv ----
/*
  Types of the power-mode sequencer: modes, control bits, clock gates.
  Assumes the cfg header supplies all numeric constants.
*/
package pms_pkg;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_ACT_HIGH,
    ST_ACT_MID,
    ST_SUBACT,
    ST_SLEEP_HIGH,
    ST_SLEEP_MID,
    ST_STANDBY,
    ST_WATCH,
    ST_SUBSLEEP,
    ST_SETTLE
  } pms_mode_t;

  typedef enum logic {
    CLK_SYS,
    CLK_SUB
  } pms_clk_src_t;

  typedef struct packed {
    logic software_standby_bit;
    logic low_speed_on_bit;
    logic medium_speed_on_bit;
    logic direct_transfer_on_bit;
    logic watch_select_timer_bit;
    logic [2:0] settle_time_sel;
    logic mid_clock_div_hi;
    logic mid_clock_div_lo;
  } pms_ctrl_t;

  typedef struct packed {
    logic timer_a;
    logic timer_c;
    logic timer_f;
    logic timer_g;
    logic adc;
    logic watchdog_unit;
    logic serial_channel_one;
    logic serial_channel_three_one;
    logic serial_channel_three_two;
    logic pager;
    logic other;
  } pms_periph_en_t;

endpackage

// ---- design/pms_sync.sv ----
/*
  Two-flop level synchroniser, one bit per lane.
  Assumes inputs are levels held longer than two clock cycles.
*/
`timescale 1ns/100ps
module pms_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end

endmodule

// ---- design/pms_settle.sv ----
/*
  Oscillator settling timer: loads a wait from the select code on a start
  pulse and pulses done after exactly that many clock cycles.
  Assumes a new start is not given while busy.
*/
`timescale 1ns/100ps
`include "pms_cfg.svh"
module pms_settle #(
  parameter int WAIT_8192 = `PMS_WAIT_8192_DEF,
  parameter int WAIT_16384 = `PMS_WAIT_16384_DEF
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_start,
  input wire logic [2:0] i_sel,
  // Status
  output logic o_busy,
  output logic o_done
);

  logic [14:0] count_reg;
  logic [14:0] load;

  always_comb begin
    case (i_sel)
      3'h0: load = 15'(WAIT_8192);
      3'h1: load = 15'(WAIT_16384);
      3'h2: load = `PMS_WAIT_1024;
      3'h3: load = `PMS_WAIT_2048;
      3'h4: load = `PMS_WAIT_4096;
      3'h5: load = `PMS_WAIT_2;
      3'h6: load = `PMS_WAIT_8;
      default: load = `PMS_WAIT_16;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_reg <= 15'h0000;
    end else if (i_start) begin
      count_reg <= load;
    end else if (count_reg != 15'h0000) begin
      count_reg <= count_reg - 15'h0001;
    end
  end

  assign o_busy = (count_reg != 15'h0000);
  assign o_done = (count_reg == 15'h0001);

endmodule

// ---- design/pms_sequencer.sv ----
/*
  Power-mode sequencer: picks the next mode on a sleep instruction,
  gates peripheral clocks per mode, selects the CPU clock and wakes on
  enabled interrupts or the reset pin, with an oscillator settling wait on wakes from standby and from watch to active mode.
  Assumes control bits, enables and sleep strobe are synchronous to
  i_clk and that one subclock period is marked by i_sub_tick.
*/
`timescale 1ns/100ps
`include "pms_cfg.svh"
module pms_sequencer #(
  parameter int WAIT_8192 = `PMS_WAIT_8192_DEF,
  parameter int WAIT_16384 = `PMS_WAIT_16384_DEF
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // CPU side
  input wire logic i_sleep,
  input wire logic i_ccr_mask,
  input wire pms_pkg::pms_ctrl_t i_ctrl,
  input wire logic i_sa_wr,
  input wire logic [1:0] i_sa_data,
  // Interrupt controller and pins
  input wire logic [`PMS_SRC_W-1:0] i_int_req,
  input wire logic [`PMS_SRC_W-1:0] i_int_en,
  input wire logic i_dt_int_en,
  input wire logic i_reset_input_low,
  input wire logic i_sub_tick,
  // Mode and exceptions
  output pms_pkg::pms_mode_t o_mode,
  output logic o_cpu_reset,
  output logic o_int_exc_start,
  output logic o_dt_exc_start,
  output logic o_mid_entry,
  // Clocks and pins
  output logic o_cpu_run,
  output pms_pkg::pms_clk_src_t o_cpu_clk_src,
  output logic [2:0] o_cpu_div_log2,
  output logic o_osc_en,
  output logic o_io_hiz,
  output pms_pkg::pms_periph_en_t o_periph_en,
  output logic [1:0] o_sa_sel
);

  pms_pkg::pms_mode_t state_reg;
  pms_pkg::pms_mode_t state_next;
  logic dt_reg;
  logic dt_next;
  logic wake_pend_reg;
  logic int_exc_next;
  logic dt_exc_next;
  logic settle_start;
  logic settle_done;
  logic [1:0] sa_reg;
  logic [`PMS_SRC_W:0] sync_q;
  logic [`PMS_SRC_W-1:0] req_live;
  logic pin_high;
  logic dt_ok;
  logic wake_watch;
  logic wake_subsleep;
  logic wake_standby;
  logic wake_sleep;
  pms_pkg::pms_periph_en_t en_next;

  pms_sync #(
    .W(`PMS_SRC_W + 1)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_reset_input_low, i_int_req}),
    .o_q(sync_q)
  );

  pms_settle #(
    .WAIT_8192(WAIT_8192),
    .WAIT_16384(WAIT_16384)
  ) u_settle (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(settle_start),
    .i_sel(i_ctrl.settle_time_sel),
    .o_busy(),
    .o_done(settle_done)
  );

  assign pin_high = sync_q[`PMS_SRC_W];

  // masked or disabled requests never wake
  assign req_live = (i_ccr_mask) ? '0 : (sync_q[`PMS_SRC_W-1:0] & i_int_en);
  assign wake_watch = |(req_live & `PMS_MASK_WATCH);
  assign wake_subsleep = |(req_live & `PMS_MASK_SUBSLEEP);
  assign wake_standby = |(req_live & `PMS_MASK_STANDBY);
  assign wake_sleep = |(req_live & `PMS_MASK_SLEEP);
  // direct transfer only with its interrupt usable
  assign dt_ok = i_ctrl.direct_transfer_on_bit & i_dt_int_en & ~i_ccr_mask;

  always_comb begin
    state_next = state_reg;
    dt_next = 1'b0;
    int_exc_next = 1'b0;
    dt_exc_next = 1'b0;
    settle_start = 1'b0;
    if (!pin_high) begin
      state_next = pms_pkg::ST_RESET;
    end else begin
      case (state_reg)
        pms_pkg::ST_RESET: begin
          state_next = pms_pkg::ST_ACT_HIGH;
        end
        pms_pkg::ST_ACT_HIGH, pms_pkg::ST_ACT_MID: begin
          if (i_sleep) begin
            if (dt_ok && !i_ctrl.software_standby_bit && !i_ctrl.low_speed_on_bit) begin
              state_next = i_ctrl.medium_speed_on_bit ? pms_pkg::ST_SLEEP_MID
                                                      : pms_pkg::ST_SLEEP_HIGH;
              dt_next = 1'b1;
            end else if (dt_ok && i_ctrl.software_standby_bit && i_ctrl.low_speed_on_bit
                         && i_ctrl.watch_select_timer_bit) begin
              state_next = pms_pkg::ST_WATCH;
              dt_next = 1'b1;
            end else if (i_ctrl.software_standby_bit && i_ctrl.watch_select_timer_bit) begin
              state_next = pms_pkg::ST_WATCH;
            end else if (i_ctrl.software_standby_bit && !i_ctrl.low_speed_on_bit) begin
              state_next = pms_pkg::ST_STANDBY;
            end else if (!i_ctrl.software_standby_bit && !i_ctrl.low_speed_on_bit) begin
              state_next = i_ctrl.medium_speed_on_bit ? pms_pkg::ST_SLEEP_MID
                                                      : pms_pkg::ST_SLEEP_HIGH;
            end
          end
        end
        pms_pkg::ST_SUBACT: begin
          if (i_sleep) begin
            if (dt_ok && i_ctrl.software_standby_bit && !i_ctrl.low_speed_on_bit
                && i_ctrl.watch_select_timer_bit) begin
              state_next = pms_pkg::ST_WATCH;
              dt_next = 1'b1;
            end else if (i_ctrl.software_standby_bit && i_ctrl.watch_select_timer_bit) begin
              state_next = pms_pkg::ST_WATCH;
            end else if (!i_ctrl.software_standby_bit && i_ctrl.low_speed_on_bit
                         && i_ctrl.watch_select_timer_bit) begin
              state_next = pms_pkg::ST_SUBSLEEP;
            end
          end
        end
        pms_pkg::ST_SLEEP_HIGH, pms_pkg::ST_SLEEP_MID: begin
          if (dt_reg || wake_sleep) begin
            state_next = (state_reg == pms_pkg::ST_SLEEP_MID) ? pms_pkg::ST_ACT_MID
                                                             : pms_pkg::ST_ACT_HIGH;
            dt_exc_next = dt_reg;
            int_exc_next = ~dt_reg;
          end
        end
        pms_pkg::ST_STANDBY: begin
          if (wake_standby) begin
            state_next = pms_pkg::ST_SETTLE;
            settle_start = 1'b1;
          end
        end
        pms_pkg::ST_WATCH: begin
          if (dt_reg) begin
            if (i_ctrl.low_speed_on_bit) begin
              state_next = pms_pkg::ST_SUBACT;
              dt_exc_next = 1'b1;
            end else begin
              state_next = pms_pkg::ST_SETTLE;
              settle_start = 1'b1;
              dt_next = 1'b1;
            end
          end else if (wake_watch) begin
            if (i_ctrl.low_speed_on_bit) begin
              state_next = pms_pkg::ST_SUBACT;
              int_exc_next = 1'b1;
            end else begin
              state_next = pms_pkg::ST_SETTLE;
              settle_start = 1'b1;
            end
          end
        end
        pms_pkg::ST_SUBSLEEP: begin
          if (wake_pend_reg && i_sub_tick) begin
            state_next = pms_pkg::ST_SUBACT;
            int_exc_next = 1'b1;
          end
        end
        pms_pkg::ST_SETTLE: begin
          dt_next = dt_reg;
          if (settle_done) begin
            state_next = i_ctrl.medium_speed_on_bit ? pms_pkg::ST_ACT_MID
                                                    : pms_pkg::ST_ACT_HIGH;
            dt_next = 1'b0;
            dt_exc_next = dt_reg;
            int_exc_next = ~dt_reg;
          end
        end
        default: begin
          state_next = pms_pkg::ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= pms_pkg::ST_RESET;
      dt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      dt_reg <= dt_next;
    end
  end

  // Subsleep request held until the next subclock tick
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_pend_reg <= 1'b0;
    end else if (state_reg != pms_pkg::ST_SUBSLEEP) begin
      wake_pend_reg <= 1'b0;
    end else if (wake_subsleep) begin
      wake_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_int_exc_start <= 1'b0;
      o_dt_exc_start <= 1'b0;
      o_mid_entry <= 1'b0;
    end else begin
      o_int_exc_start <= int_exc_next;
      o_dt_exc_start <= dt_exc_next;
      o_mid_entry <= (state_next == pms_pkg::ST_ACT_MID) && (state_reg != pms_pkg::ST_ACT_MID);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sa_reg <= `PMS_SA_RESET;
    end else if (i_sa_wr && state_reg != pms_pkg::ST_SUBACT) begin
      sa_reg <= i_sa_data;
    end
  end

  always_comb begin
    en_next = '1;
    case (state_next)
      pms_pkg::ST_WATCH, pms_pkg::ST_SETTLE: begin
        en_next = '0;
        en_next.timer_a = 1'b1;
        en_next.timer_f = 1'b1;
        en_next.timer_g = 1'b1;
        en_next.pager = 1'b1;
      end
      pms_pkg::ST_STANDBY: begin
        en_next = '0;
        en_next.pager = 1'b1;
      end
      pms_pkg::ST_SUBSLEEP: begin
        en_next = '0;
        en_next.adc = 1'b1;
        en_next.watchdog_unit = 1'b1;
      end
      default: begin
        en_next = '1;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_periph_en <= '1;
      o_cpu_run <= 1'b0;
      o_cpu_clk_src <= pms_pkg::CLK_SYS;
      o_cpu_div_log2 <= 3'h0;
      o_osc_en <= 1'b1;
      o_io_hiz <= 1'b0;
    end else begin
      o_periph_en <= en_next;
      o_cpu_run <= (state_next == pms_pkg::ST_ACT_HIGH) || (state_next == pms_pkg::ST_ACT_MID)
                   || (state_next == pms_pkg::ST_SUBACT);
      o_osc_en <= (state_next != pms_pkg::ST_WATCH) && (state_next != pms_pkg::ST_STANDBY)
                  && (state_next != pms_pkg::ST_SUBSLEEP) && (state_next != pms_pkg::ST_SUBACT);
      o_io_hiz <= (state_next == pms_pkg::ST_STANDBY);
      if (state_next == pms_pkg::ST_SUBACT || state_next == pms_pkg::ST_SUBSLEEP) begin
        o_cpu_clk_src <= pms_pkg::CLK_SUB;
        if (sa_reg[1]) begin
          o_cpu_div_log2 <= `PMS_SUB_LOG2_DIV2;
        end else if (sa_reg[0]) begin
          o_cpu_div_log2 <= `PMS_SUB_LOG2_DIV4;
        end else begin
          o_cpu_div_log2 <= `PMS_SUB_LOG2_DIV8;
        end
      end else if (state_next == pms_pkg::ST_ACT_MID || state_next == pms_pkg::ST_SLEEP_MID) begin
        o_cpu_clk_src <= pms_pkg::CLK_SYS;
        o_cpu_div_log2 <= 3'(`PMS_MID_LOG2_BASE
                          + {1'b0, i_ctrl.mid_clock_div_hi, i_ctrl.mid_clock_div_lo});
      end else begin
        o_cpu_clk_src <= pms_pkg::CLK_SYS;
        o_cpu_div_log2 <= 3'h0;
      end
    end
  end

  assign o_mode = state_reg;
  assign o_cpu_reset = (state_reg == pms_pkg::ST_RESET);
  assign o_sa_sel = sa_reg;

  // Checks
  sequence s_dt_to_mid;
    (state_reg == pms_pkg::ST_ACT_HIGH) && i_sleep && pin_high && dt_ok
      && !i_ctrl.software_standby_bit && !i_ctrl.low_speed_on_bit
      && i_ctrl.medium_speed_on_bit;
  endsequence

  sequence s_pass_mid;
    (state_reg == pms_pkg::ST_SLEEP_MID) ##1 (state_reg == pms_pkg::ST_ACT_MID) && o_dt_exc_start;
  endsequence

  chk_watch_entry: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_ACT_HIGH) && i_sleep && pin_high && !dt_ok
      && i_ctrl.software_standby_bit && i_ctrl.watch_select_timer_bit
    |=> state_reg == pms_pkg::ST_WATCH)
    else $error("watch not entered");

  chk_watch_gates: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_WATCH) |-> o_periph_en.timer_a && o_periph_en.timer_g
      && !o_periph_en.timer_c && !o_periph_en.adc && !o_cpu_run)
    else $error("watch clock gating wrong");

  chk_masked_hold: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_WATCH) && !dt_reg && i_ccr_mask && pin_high
    |=> state_reg == pms_pkg::ST_WATCH)
    else $error("masked wake left watch");

  chk_subsleep_entry: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_SUBACT) && i_sleep && pin_high && !i_ctrl.software_standby_bit
      && i_ctrl.low_speed_on_bit && i_ctrl.watch_select_timer_bit
    |=> state_reg == pms_pkg::ST_SUBSLEEP)
    else $error("subsleep not entered");

  chk_subsleep_wake: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_SUBSLEEP) && wake_pend_reg && i_sub_tick && pin_high
    |=> (state_reg == pms_pkg::ST_SUBACT) && o_int_exc_start)
    else $error("subsleep wake missed tick");

  chk_sub_divider: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_SUBACT) && ($past(state_reg) == pms_pkg::ST_SUBACT)
    |-> (o_cpu_div_log2 == (sa_reg[1] ? 3'h1 : (sa_reg[0] ? 3'h2 : 3'h3)))
      && (o_cpu_clk_src == pms_pkg::CLK_SUB))
    else $error("subactive divider wrong");

  chk_sa_locked: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_SUBACT) && i_sa_wr |=> $stable(sa_reg))
    else $error("divider select changed in subactive");

  chk_settle_time: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_SETTLE) && ($past(state_reg) != pms_pkg::ST_SETTLE)
      && ($past(i_ctrl.settle_time_sel) == 3'h6) && (i_ctrl.settle_time_sel == 3'h6)
      && pin_high
    |-> (state_reg == pms_pkg::ST_SETTLE)[*8] ##1 (state_reg != pms_pkg::ST_SETTLE))
    else $error("settle wait length wrong");

  chk_dt_mid: assert property (
    @(posedge i_clk) disable iff (i_rst || !i_reset_input_low)
    s_dt_to_mid |=> s_pass_mid)
    else $error("direct move to medium failed");

  chk_standby_entry: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == pms_pkg::ST_ACT_MID) && i_sleep && pin_high && !dt_ok
      && i_ctrl.software_standby_bit && !i_ctrl.low_speed_on_bit
      && !i_ctrl.watch_select_timer_bit
    |=> (state_reg == pms_pkg::ST_STANDBY) && o_io_hiz)
    else $error("standby not entered");

endmodule

// ---- testbench/pms_cpu_model.sv ----
/*
  CPU core and interrupt controller model: sleep strobe, held interrupt
  requests and a subclock tick every eight clocks.
  Assumes the bench calls its tasks and drives on the falling edge.
*/
`timescale 1ns/100ps
module pms_cpu_model (
  // Clock and service strobe
  input wire logic i_clk,
  input wire logic i_exc,
  // Towards the sequencer
  output logic o_sleep,
  output logic [19:0] o_int_req,
  output logic o_sub_tick
);
  logic [2:0] tick_reg;
  initial begin
    o_sleep = 1'h0;
    o_int_req = 20'h00000;
    tick_reg = 3'h0;
  end
  assign o_sub_tick = (tick_reg == 3'h7);
  always @(negedge i_clk) begin
    tick_reg <= tick_reg + 3'h1;
    if (i_exc) begin
      o_int_req <= 20'h00000;
    end
  end
  task sleep_op;
    @(negedge i_clk);
    o_sleep = 1'h1;
    @(negedge i_clk);
    o_sleep = 1'h0;
  endtask
  task raise(input int s);
    @(negedge i_clk);
    o_int_req[s] = 1'h1;
  endtask
endmodule

// ---- testbench/testbench.sv ----
/*
  Self-checking bench for the power-mode sequencer, one task a scenario.
  Assumes the shortened settle parameters and the CPU model beside it.
*/
`timescale 1ns/100ps
module testbench;
  logic i_clk, i_rst, i_ccr_mask, i_sa_wr, i_dt_int_en, i_reset_input_low;
  logic [1:0] i_sa_data;
  logic [19:0] i_int_en;
  pms_pkg::pms_ctrl_t i_ctrl;
  logic i_sleep, i_sub_tick, o_cpu_reset, o_int_exc_start, o_dt_exc_start, o_mid_entry;
  logic o_cpu_run, o_osc_en, o_io_hiz;
  logic [19:0] i_int_req;
  pms_pkg::pms_mode_t o_mode;
  pms_pkg::pms_clk_src_t o_cpu_clk_src;
  logic [2:0] o_cpu_div_log2;
  pms_pkg::pms_periph_en_t o_periph_en;
  logic [1:0] o_sa_sel;
  int n_errors = 0, checks = 0, cyc = 0, n;

  pms_sequencer #(.WAIT_8192(64), .WAIT_16384(128)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sleep(i_sleep), .i_ccr_mask(i_ccr_mask),
    .i_ctrl(i_ctrl), .i_sa_wr(i_sa_wr), .i_sa_data(i_sa_data), .i_int_req(i_int_req),
    .i_int_en(i_int_en), .i_dt_int_en(i_dt_int_en), .i_reset_input_low(i_reset_input_low),
    .i_sub_tick(i_sub_tick), .o_mode(o_mode), .o_cpu_reset(o_cpu_reset),
    .o_int_exc_start(o_int_exc_start), .o_dt_exc_start(o_dt_exc_start),
    .o_mid_entry(o_mid_entry), .o_cpu_run(o_cpu_run), .o_cpu_clk_src(o_cpu_clk_src),
    .o_cpu_div_log2(o_cpu_div_log2), .o_osc_en(o_osc_en), .o_io_hiz(o_io_hiz),
    .o_periph_en(o_periph_en),
    .o_sa_sel(o_sa_sel));
  pms_cpu_model u_cpu (.i_clk(i_clk), .i_exc(o_int_exc_start), .o_sleep(i_sleep),
    .o_int_req(i_int_req), .o_sub_tick(i_sub_tick));

  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      test_done();
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wait_mode(input pms_pkg::pms_mode_t m, input int mx);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_mode !== m && n < mx);
  endtask
  task sa_write(input logic [1:0] d);
    i_sa_data = d;
    i_sa_wr = 1'h1;
    @(negedge i_clk);
    i_sa_wr = 1'h0;
  endtask
  task test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task t_watch;
    i_ctrl = {5'h11, 3'h6, 2'h0};
    u_cpu.sleep_op();
    chk(o_mode, pms_pkg::ST_WATCH);
    chk(o_periph_en, 11'h582);
    u_cpu.raise(1);
    repeat (8) @(negedge i_clk);
    chk(o_mode, pms_pkg::ST_WATCH);
    i_ccr_mask = 1'h1;
    u_cpu.raise(0);
    repeat (8) @(negedge i_clk);
    chk(o_mode, pms_pkg::ST_WATCH);
    i_ccr_mask = 1'h0;
    wait_mode(pms_pkg::ST_SETTLE, 6);
    wait_mode(pms_pkg::ST_ACT_HIGH, 20);
    chk(16'(n), 16'h0008);
    chk(o_int_exc_start, 1'h1);
    chk(o_mode, pms_pkg::ST_ACT_HIGH);
  endtask
  task t_dt_mid;
    i_ctrl = {5'h06, 3'h6, 2'h1};
    u_cpu.sleep_op();
    chk(o_mode, pms_pkg::ST_SLEEP_MID);
    wait_mode(pms_pkg::ST_ACT_MID, 3);
    chk(16'(n), 16'h0001);
    chk(o_dt_exc_start, 1'h1);
    chk(o_mid_entry, 1'h1);
    chk(o_cpu_div_log2, 3'h4);
  endtask
  task t_to_sub;
    sa_write(2'h1);
    chk(o_sa_sel, 2'h1);
    i_ctrl = {5'h1B, 3'h6, 2'h1};
    u_cpu.sleep_op();
    chk(o_mode, pms_pkg::ST_WATCH);
    wait_mode(pms_pkg::ST_SUBACT, 4);
    chk(o_mode, pms_pkg::ST_SUBACT);
    chk(o_cpu_clk_src, pms_pkg::CLK_SUB);
    chk(o_cpu_div_log2, 3'h2);
    sa_write(2'h2);
    @(negedge i_clk);
    chk(o_sa_sel, 2'h1);
  endtask
  task t_subsleep;
    i_ctrl = {5'h09, 3'h6, 2'h1};
    u_cpu.sleep_op();
    chk(o_mode, pms_pkg::ST_SUBSLEEP);
    chk(o_periph_en, 11'h060);
    u_cpu.raise(1);
    wait_mode(pms_pkg::ST_SUBACT, 20);
    chk(o_mode, pms_pkg::ST_SUBACT);
    chk(o_int_exc_start, 1'h1);
  endtask
  task t_sub_to_mid;
    i_ctrl = {5'h17, 3'h7, 2'h0};
    u_cpu.sleep_op();
    chk(o_mode, pms_pkg::ST_WATCH);
    wait_mode(pms_pkg::ST_SETTLE, 4);
    wait_mode(pms_pkg::ST_ACT_MID, 30);
    chk(16'(n), 16'h0010);
    chk(o_dt_exc_start, 1'h1);
    chk(o_cpu_div_log2, 3'h3);
  endtask
  task t_dt_off;
    i_dt_int_en = 1'h0;
    i_ctrl = {5'h06, 3'h6, 2'h0};
    u_cpu.sleep_op();
    repeat (4) @(negedge i_clk);
    chk(o_mode, pms_pkg::ST_SLEEP_MID);
    u_cpu.raise(2);
    wait_mode(pms_pkg::ST_ACT_MID, 6);
    chk(o_int_exc_start, 1'h1);
  endtask
  task t_standby;
    i_ctrl = {5'h10, 3'h6, 2'h0};
    u_cpu.sleep_op();
    chk(o_mode, pms_pkg::ST_STANDBY);
    chk(o_io_hiz, 1'h1);
    chk(o_osc_en, 1'h0);
    chk(o_cpu_run, 1'h0);
    chk(o_periph_en, 11'h002);
    i_int_en = 20'hFFEFF;
    u_cpu.raise(8);
    repeat (6) @(negedge i_clk);
    chk(o_mode, pms_pkg::ST_STANDBY);
    i_int_en = 20'hFFFFF;
    wait_mode(pms_pkg::ST_SETTLE, 6);
    chk(16'(n), 16'h0001);
    wait_mode(pms_pkg::ST_ACT_HIGH, 20);
    chk(16'(n), 16'h0008);
    chk(o_int_exc_start, 1'h1);
    chk(o_cpu_run, 1'h1);
    chk(o_osc_en, 1'h1);
    chk(o_io_hiz, 1'h0);
  endtask

  initial begin
    i_rst = 1'h1;
    i_ccr_mask = 1'h0;
    i_sa_wr = 1'h0;
    i_sa_data = 2'h0;
    i_dt_int_en = 1'h1;
    i_reset_input_low = 1'h1;
    i_int_en = 20'hFFFFF;
    i_ctrl = {5'h00, 3'h6, 2'h0};
    repeat (12) @(negedge i_clk);
    chk(o_cpu_reset, 1'h1);
    i_rst = 1'h0;
    wait_mode(pms_pkg::ST_ACT_HIGH, 6);
    chk(o_mode, pms_pkg::ST_ACT_HIGH);
    chk(16'(n), 16'h0003);
    t_watch();
    t_dt_mid();
    t_to_sub();
    t_subsleep();
    t_sub_to_mid();
    t_dt_off();
    t_standby();
    i_reset_input_low = 1'h0;
    wait_mode(pms_pkg::ST_RESET, 5);
    chk(o_mode, pms_pkg::ST_RESET);
    chk(16'(n), 16'h0003);
    chk(o_cpu_reset, 1'h1);
    test_done();
  end
endmodule
